/* File: hw/cspw_ctrl.sv */
// power, standby, range and wake control with register port
// How it works
// - channel-2 range bits 5:4, 5/10/20/20 pF
// - reserved range and power bits read zero
// - power-down register at offset 03h
// - standby bit puts both channels in standby
// - standby converts at divided-down rate
// - software may clear standby by writing zero
// - wake event on either channel clears standby
// - bit 1 powers channel 1 down
// - bit 2 powers channel 2 down
// - channel-1 wake control at 04h, read/write
// - bit 0 enables channel-1 absolute wake
// - bit 1 enables channel-1 rate wake
`timescale 1ns/1ns
`default_nettype none
module cspw_ctrl (
    input  wire logic                         clk_in,
    input  wire logic                         rst_b_in,
    input  wire logic [cspw_pkg::ADDR_W-1:0]  addr_in,
    input  wire logic [cspw_pkg::DATA_W-1:0]  wdata_in,
    input  wire logic                         wr_in,
    input  wire logic                         rd_in,
    output logic      [cspw_pkg::DATA_W-1:0]  rdata_out,
    input  wire cspw_pkg::cspw_result_t       ch1_result_in,
    input  wire cspw_pkg::cspw_result_t       ch2_result_in,
    input  wire cspw_pkg::cspw_thresh_t       ch1_thresh_in,
    input  wire cspw_pkg::cspw_thresh_t       ch2_thresh_in,
    input  wire logic [1:0]                   ch2_wake_enable_in,
    output logic      [1:0]                   conv_start_out,
    output logic                              standby_out,
    output logic                              ch1_power_off_out,
    output logic                              ch2_power_off_out,
    output logic      [4:0]                   ch1_range_pf_out,
    output logic      [4:0]                   ch2_range_pf_out,
    output logic                              wake_out,
    output logic                              irq_out
);

    logic                                    rst_meta;
    logic                                    rst_n;
    logic [7:0]                              input_range_select;
    cspw_pkg::cspw_power_t                   power_down_control;
    logic [7:0]                              ch1_wake_control;
    logic [7:0]                              standby_divider;
    logic [2:0]                              standby_step;
    logic [cspw_pkg::IRQ_W-1:0]              irq_status;
    logic [cspw_pkg::IRQ_W-1:0]              irq_enable;
    logic [1:0]                              ch_wake;
    logic                                    wake_any;
    logic                                    wr_range;
    logic                                    wr_power;
    logic                                    wr_wake1;
    logic                                    wr_div;
    logic                                    wr_step;
    logic                                    wr_clear;
    logic                                    wr_enable;
    logic [cspw_pkg::PERIOD_CNT_W-1:0]       period_cnt;
    logic                                    period_tick;
    logic [cspw_pkg::SB_CNT_W-1:0]           sb_cnt;
    logic [cspw_pkg::SB_CNT_W-1:0]           sb_limit;
    logic                                    conv_fire;
    cspw_pkg::cspw_sched_t                   sched;
    cspw_pkg::cspw_sched_t                   next_sched;
    logic [cspw_pkg::IRQ_W-1:0]              irq_events;
    logic [cspw_pkg::DATA_W-1:0]             next_rdata;
    logic [1:0]                              powered;
    logic [1:0]                              abs_en;
    logic [1:0]                              rate_en;
    cspw_pkg::cspw_result_t [1:0]            results;
    cspw_pkg::cspw_thresh_t [1:0]            threshs;

    // ****************************************
    // reset release
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************
    // write decode
    // ****************************************
    assign wr_range  = wr_in && (addr_in == cspw_pkg::OFS_RANGE);
    assign wr_power  = wr_in && (addr_in == cspw_pkg::OFS_POWER);
    assign wr_wake1  = wr_in && (addr_in == cspw_pkg::OFS_WAKE1);
    assign wr_div    = wr_in && (addr_in == cspw_pkg::OFS_SB_DIV);
    assign wr_step   = wr_in && (addr_in == cspw_pkg::OFS_SB_STEP);
    assign wr_clear  = wr_in && (addr_in == cspw_pkg::OFS_IRQ_CLEAR);
    assign wr_enable = wr_in && (addr_in == cspw_pkg::OFS_IRQ_ENABLE);

    // ****************************************
    // range register
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            input_range_select <= cspw_pkg::RANGE_RESET;
        end else if (wr_range) begin
            input_range_select <= wdata_in & cspw_pkg::RANGE_MASK;
        end
    end

    assign ch1_range_pf_out = cspw_pkg::range_pf(input_range_select[cspw_pkg::RANGE_CH1_LSB +: 2]);
    assign ch2_range_pf_out = cspw_pkg::range_pf(input_range_select[cspw_pkg::RANGE_CH2_LSB +: 2]);

    // ****************************************
    // power-down register
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            power_down_control <= cspw_pkg::POWER_RESET[2:0];
        end else begin
            if (wr_power) begin
                power_down_control.ch1_power_off <= wdata_in[cspw_pkg::PD_CH1_BIT];
                power_down_control.ch2_power_off <= wdata_in[cspw_pkg::PD_CH2_BIT];
            end
            if (wake_any) begin
                power_down_control.standby_enable <= 1'b0;
            end else if (wr_power) begin
                power_down_control.standby_enable <= wdata_in[cspw_pkg::PD_STANDBY_BIT];
            end
        end
    end

    assign standby_out       = power_down_control.standby_enable;
    assign ch1_power_off_out = power_down_control.ch1_power_off;
    assign ch2_power_off_out = power_down_control.ch2_power_off;

    // ****************************************
    // wake control and standby rate registers
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ch1_wake_control <= cspw_pkg::WAKE1_RESET;
        end else if (wr_wake1) begin
            ch1_wake_control <= wdata_in & cspw_pkg::WAKE1_MASK;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            standby_divider <= cspw_pkg::SB_DIV_RESET;
            standby_step    <= cspw_pkg::SB_STEP_RESET[2:0];
        end else begin
            if (wr_div) begin
                standby_divider <= wdata_in;
            end
            if (wr_step) begin
                standby_step <= wdata_in[2:0];
            end
        end
    end

    // ****************************************
    // conversion scheduler
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            period_cnt <= '0;
        end else if (period_tick) begin
            period_cnt <= '0;
        end else begin
            period_cnt <= period_cnt + 1'b1;
        end
    end

    assign period_tick = (period_cnt == cspw_pkg::PERIOD_CNT_W'(cspw_pkg::CONV_PERIOD_CYC - 1));
    assign sb_limit    = cspw_pkg::SB_CNT_W'(({8'h00, standby_divider} + 16'h0001) << standby_step);

    always_comb begin
        case (sched)
            cspw_pkg::SCHED_OFF,
            cspw_pkg::SCHED_NORMAL,
            cspw_pkg::SCHED_STANDBY: begin
                if (powered == 2'b00) begin
                    next_sched = cspw_pkg::SCHED_OFF;
                end else begin
                    next_sched = standby_out ? cspw_pkg::SCHED_STANDBY : cspw_pkg::SCHED_NORMAL;
                end
            end
            default: begin
                next_sched = cspw_pkg::SCHED_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sched <= cspw_pkg::SCHED_OFF;
        end else begin
            sched <= next_sched;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sb_cnt <= '0;
        end else if (sched != cspw_pkg::SCHED_STANDBY) begin
            sb_cnt <= '0;
        end else if (period_tick) begin
            sb_cnt <= (sb_cnt >= sb_limit - 16'h0001) ? '0 : sb_cnt + 16'h0001;
        end
    end

    always_comb begin
        case (sched)
            cspw_pkg::SCHED_NORMAL:  conv_fire = period_tick;
            cspw_pkg::SCHED_STANDBY: conv_fire = period_tick && (sb_cnt >= sb_limit - 16'h0001);
            default:       conv_fire = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            conv_start_out <= 2'b00;
        end else begin
            conv_start_out <= {2{conv_fire}} & powered;
        end
    end

    // ****************************************
    // wake detection
    // ****************************************
    assign powered = {~power_down_control.ch2_power_off, ~power_down_control.ch1_power_off};
    assign abs_en  = {ch2_wake_enable_in[0], ch1_wake_control[cspw_pkg::WAKE_ABS_BIT]};
    assign rate_en = {ch2_wake_enable_in[1], ch1_wake_control[cspw_pkg::WAKE_RATE_BIT]};
    assign results = {ch2_result_in, ch1_result_in};
    assign threshs = {ch2_thresh_in, ch1_thresh_in};

    generate
        for (genvar ch = 0; ch < cspw_pkg::NUM_CH; ch++) begin : g_wake
            cspw_wake_detect u_wake (
                .clk_in         (clk_in),
                .rst_b_in       (rst_n),
                .result_in      (results[ch]),
                .thresh_in      (threshs[ch]),
                .abs_enable_in  (abs_en[ch]),
                .rate_enable_in (rate_en[ch]),
                .powered_in     (powered[ch]),
                .wake_out       (ch_wake[ch])
            );
        end
    endgenerate

    assign wake_any = |ch_wake;
    assign wake_out = wake_any;

    // ****************************************
    // interrupts
    // ****************************************
    assign irq_events = {ch1_result_in.valid | ch2_result_in.valid, ch_wake[1], ch_wake[0]};

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= cspw_pkg::IRQ_RESET;
        end else begin
            irq_status <= (irq_status & ~(wr_clear ? wdata_in[cspw_pkg::IRQ_W-1:0] : 3'h0)) | irq_events;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable <= cspw_pkg::IRQ_RESET;
        end else if (wr_enable) begin
            irq_enable <= wdata_in[cspw_pkg::IRQ_W-1:0];
        end
    end

    assign irq_out = |(irq_status & irq_enable);

    // ****************************************
    // read port
    // ****************************************
    always_comb begin
        next_rdata = 8'h00;
        case (addr_in)
            cspw_pkg::OFS_RANGE:      next_rdata = input_range_select;
            cspw_pkg::OFS_POWER:      next_rdata = {5'h00, power_down_control};
            cspw_pkg::OFS_WAKE1:      next_rdata = ch1_wake_control;
            cspw_pkg::OFS_SB_DIV:     next_rdata = standby_divider;
            cspw_pkg::OFS_SB_STEP:    next_rdata = {5'h00, standby_step};
            cspw_pkg::OFS_IRQ_STATUS: next_rdata = {5'h00, irq_status};
            cspw_pkg::OFS_IRQ_ENABLE: next_rdata = {5'h00, irq_enable};
            default:                  next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= 8'h00;
        end
    end

endmodule
`default_nettype wire

/* File: hw/cspw_pkg.sv */
// shared constants and types for the capacitive sense power and wake control
package cspw_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned RES_W  = 12;
    localparam int unsigned NUM_CH = 2;
    localparam int unsigned IRQ_W  = 3;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_RANGE      = 8'h02;
    localparam logic [7:0] OFS_POWER      = 8'h03;
    localparam logic [7:0] OFS_WAKE1      = 8'h04;
    localparam logic [7:0] OFS_SB_DIV     = 8'h10;
    localparam logic [7:0] OFS_SB_STEP    = 8'h11;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h12;
    localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h13;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;

    // ****************************************
    // field positions and writable masks
    // ****************************************
    localparam int unsigned RANGE_CH1_LSB  = 0;
    localparam int unsigned RANGE_CH2_LSB  = 4;
    localparam int unsigned PD_STANDBY_BIT = 0;
    localparam int unsigned PD_CH1_BIT     = 1;
    localparam int unsigned PD_CH2_BIT     = 2;
    localparam int unsigned WAKE_ABS_BIT   = 0;
    localparam int unsigned WAKE_RATE_BIT  = 1;
    localparam int unsigned IRQ_WAKE1_BIT  = 0;
    localparam int unsigned IRQ_WAKE2_BIT  = 1;
    localparam int unsigned IRQ_CONV_BIT   = 2;
    localparam logic [7:0] RANGE_MASK = 8'h33;
    localparam logic [7:0] POWER_MASK = 8'h07;
    localparam logic [7:0] WAKE1_MASK = 8'h03;
    localparam logic [7:0] STEP_MASK  = 8'h07;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RANGE_RESET   = 8'h00;
    localparam logic [7:0] POWER_RESET   = 8'h00;
    localparam logic [7:0] WAKE1_RESET   = 8'h00;
    localparam logic [7:0] SB_DIV_RESET  = 8'h00;
    localparam logic [7:0] SB_STEP_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET     = 3'h0;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_MHZ         = 50;
    localparam int unsigned CONV_PERIOD_US  = 10;
    localparam int unsigned CONV_PERIOD_CYC = CONV_PERIOD_US * CLK_MHZ;
    localparam int unsigned PERIOD_CNT_W    = 9;
    localparam int unsigned SB_CNT_W        = 16;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic             valid;
        logic [RES_W-1:0] value;
    } cspw_result_t;

    typedef struct packed {
        logic [RES_W-1:0] absolute;
        logic [RES_W-1:0] rate;
    } cspw_thresh_t;

    typedef struct packed {
        logic ch2_power_off;
        logic ch1_power_off;
        logic standby_enable;
    } cspw_power_t;

    typedef enum logic [1:0] {
        SCHED_OFF,
        SCHED_NORMAL,
        SCHED_STANDBY
    } cspw_sched_t;

    // full-scale range in pF from a two-bit range code
    function automatic logic [4:0] range_pf(input logic [1:0] code);
        case (code)
            2'h0:    range_pf = 5'h05;
            2'h1:    range_pf = 5'h0A;
            default: range_pf = 5'h14;
        endcase
    endfunction

endpackage

/* File: hw/cspw_wake_detect.sv */
// per-channel absolute and rate-of-change wake detector
`timescale 1ns/1ns
`default_nettype none
module cspw_wake_detect (
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    input  wire cspw_pkg::cspw_result_t result_in,
    input  wire cspw_pkg::cspw_thresh_t thresh_in,
    input  wire logic                  abs_enable_in,
    input  wire logic                  rate_enable_in,
    input  wire logic                  powered_in,
    output logic                       wake_out
);

    logic [cspw_pkg::RES_W-1:0] prev;
    logic                       have_prev;
    logic [cspw_pkg::RES_W-1:0] delta;
    logic                       abs_hit;
    logic                       rate_hit;

    // ****************************************
    // threshold compare
    // ****************************************
    assign delta    = (result_in.value >= prev) ? (result_in.value - prev) : (prev - result_in.value);
    assign abs_hit  = abs_enable_in && (result_in.value > thresh_in.absolute);
    assign rate_hit = rate_enable_in && have_prev && (delta > thresh_in.rate);

    // ****************************************
    // previous sample
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prev      <= '0;
            have_prev <= 1'b0;
        end else if (!powered_in) begin
            have_prev <= 1'b0;
        end else if (result_in.valid) begin
            prev      <= result_in.value;
            have_prev <= 1'b1;
        end
    end

    // ****************************************
    // wake pulse
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wake_out <= 1'b0;
        end else begin
            wake_out <= powered_in && result_in.valid && (abs_hit || rate_hit);
        end
    end

endmodule
`default_nettype wire

/* File: testbench/cspw_ctrl_monitor.sv */
// concurrent checks on the power and wake control ports
`timescale 1ns/1ns
`default_nettype none
module cspw_ctrl_monitor (
    input wire logic                   clk_in,
    input wire logic                   rst_b_in,
    input wire logic [7:0]             addr_in,
    input wire logic [7:0]             wdata_in,
    input wire logic                   wr_in,
    input wire logic                   rd_in,
    input wire logic [7:0]             rdata_out,
    input wire cspw_pkg::cspw_result_t ch1_result_in,
    input wire cspw_pkg::cspw_result_t ch2_result_in,
    input wire logic [1:0]             conv_start_out,
    input wire logic                   standby_out,
    input wire logic                   ch1_power_off_out,
    input wire logic                   ch2_power_off_out,
    input wire logic [4:0]             ch2_range_pf_out,
    input wire logic                   wake_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    function automatic logic [4:0] pf(input logic [1:0] c);
        pf = (c == 2'h0) ? 5'h05 : (c == 2'h1) ? 5'h0A : 5'h14;
    endfunction
    logic wr_pd;
    assign wr_pd = wr_in && addr_in == cspw_pkg::OFS_POWER;
    // ****************************************
    // properties
    // ****************************************
    property p_rd_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
    property p_range; wr_in && addr_in == cspw_pkg::OFS_RANGE |=> ch2_range_pf_out == pf($past(wdata_in[5:4]));
    endproperty
    property p_rd_range; rd_in && addr_in == cspw_pkg::OFS_RANGE |=> rdata_out[7:6] == 2'h0 && rdata_out[3:2] == 2'h0;
    endproperty
    property p_pd_wr; wr_pd |=> {ch2_power_off_out, ch1_power_off_out} == $past(wdata_in[2:1]); endproperty
    property p_sb_wr; wr_pd && !wake_out |=> standby_out == $past(wdata_in[0]); endproperty
    property p_wake_clr; wake_out |=> !standby_out; endproperty
    property p_rd_pd; rd_in && addr_in == cspw_pkg::OFS_POWER |=>
        rdata_out == {5'h00, $past(ch2_power_off_out), $past(ch1_power_off_out), $past(standby_out)}; endproperty
    property p_rd_wake1; rd_in && addr_in == cspw_pkg::OFS_WAKE1 |=> rdata_out[7:2] == 6'h00; endproperty
    property p_conv_off; !(conv_start_out[0] && $past(ch1_power_off_out) && $past(ch1_power_off_out, 2))
        && !(conv_start_out[1] && $past(ch2_power_off_out) && $past(ch2_power_off_out, 2)); endproperty
    property p_wake_src; wake_out |-> ($past(ch1_result_in.valid) && !$past(ch1_power_off_out))
        || ($past(ch2_result_in.valid) && !$past(ch2_power_off_out)); endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
    a_range: assert property (p_range) else $error("range decode wrong");
    a_rd_range: assert property (p_rd_range) else $error("range reserved bits set");
    a_pd_wr: assert property (p_pd_wr) else $error("power bits not written");
    a_sb_wr: assert property (p_sb_wr) else $error("standby bit not written");
    a_wake_clr: assert property (p_wake_clr) else $error("standby kept after wake");
    a_rd_pd: assert property (p_rd_pd) else $error("power read wrong");
    a_rd_wake1: assert property (p_rd_wake1) else $error("wake control reserved bits set");
    a_conv_off: assert property (p_conv_off) else $error("start to powered-off channel");
    a_wake_src: assert property (p_wake_src) else $error("wake without powered result");
    c_wake: cover property (wake_out);
    c_conv: cover property (conv_start_out[0]);
    c_pd: cover property (wr_pd ##1 rd_in);
endmodule
bind cspw_ctrl cspw_ctrl_monitor u_mon (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ch1_result_in(ch1_result_in),
    .ch2_result_in(ch2_result_in), .conv_start_out(conv_start_out), .standby_out(standby_out),
    .ch1_power_off_out(ch1_power_off_out), .ch2_power_off_out(ch2_power_off_out),
    .ch2_range_pf_out(ch2_range_pf_out), .wake_out(wake_out));
`default_nettype wire

/* File: testbench/cspw_front_model.sv */
// conversion front-end model answering start pulses with results
`timescale 1ns/1ns
`default_nettype none
module cspw_front_model #(
    parameter int unsigned LAT = 3
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  start_in,
    input  wire logic [11:0]           value_in,
    output var  cspw_pkg::cspw_result_t result_out
);
    int unsigned cnt;
    // ****************************************
    // result after fixed latency, value toggles when idle
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt <= 0;
            result_out <= '0;
        end else begin
            result_out.valid <= 1'b0;
            result_out.value <= ~result_out.value;
            if (start_in)
                cnt <= LAT;
            else if (cnt != 0)
                cnt <= cnt - 1;
            if (cnt == 1) begin
                result_out.valid <= 1'b1;
                result_out.value <= value_in;
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/cspw_power_wake_ctrl_tb_top.sv */
// self-checking bench for the power and wake control
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module cap_sense_power_wake_ctrl_tb_top;
    logic clk_in, rst_b_in, wr_in, rd_in, standby_out, ch1_off, ch2_off, wake_out, irq_out;
    logic [7:0]  addr_in, wdata_in, rdata_out, d, x;
    logic [4:0]  pf1, pf2;
    logic [1:0]  conv, ch2_en;
    logic [11:0] v1, v2;
    logic [47:0] cs [6] = '{48'h01_01_050_200_1_1, 48'h01_00_050_200_1_0, 48'h01_02_050_0F0_1_1,
        48'h01_01_050_0F0_1_0, 48'h03_01_050_200_1_0, 48'h01_01_050_200_0_1};
    logic [7:0]  ofs [7] = '{8'h02, 8'h03, 8'h04, 8'h10, 8'h11, 8'h12, 8'h14};
    cspw_pkg::cspw_result_t res1, res2;
    cspw_pkg::cspw_thresh_t th1, th2;
    int n_mismatch = 0, cmp_count = 0, wake_cnt = 0, conv_cnt = 0, w0;
    cspw_ctrl dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .ch1_result_in(res1), .ch2_result_in(res2), .ch1_thresh_in(th1),
        .ch2_thresh_in(th2), .ch2_wake_enable_in(ch2_en), .conv_start_out(conv), .standby_out(standby_out),
        .ch1_power_off_out(ch1_off), .ch2_power_off_out(ch2_off), .ch1_range_pf_out(pf1),
        .ch2_range_pf_out(pf2), .wake_out(wake_out), .irq_out(irq_out));
    cspw_front_model u_fe1 (.clk_in(clk_in), .rst_b_in(rst_b_in), .start_in(conv[0]), .value_in(v1),
        .result_out(res1));
    cspw_front_model u_fe2 (.clk_in(clk_in), .rst_b_in(rst_b_in), .start_in(conv[1]), .value_in(v2),
        .result_out(res2));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [4:0] pf(input logic [1:0] c);
        pf = (c == 2'h0) ? 5'h05 : (c == 2'h1) ? 5'h0A : 5'h14;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= dv;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] dv);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        dv = rdata_out;
    endtask
    task automatic wait_res();
        int k = 0;
        do begin
            @(posedge clk_in);
            #1;
            k++;
        end while (res1.valid !== 1'b1 && k < 1200);
    endtask
    task automatic wake_case(input logic [47:0] c);
        wr(cspw_pkg::OFS_WAKE1, c[39:32]);
        wr(cspw_pkg::OFS_IRQ_ENABLE, {4'h0, c[7:4]});
        v1 <= c[31:20];
        wait_res();
        repeat (4) @(posedge clk_in);
        wr(cspw_pkg::OFS_IRQ_CLEAR, 8'hFF);
        wr(cspw_pkg::OFS_POWER, c[47:40]);
        w0 = wake_cnt;
        v1 <= c[19:8];
        wait_res();
        repeat (4) @(posedge clk_in);
        #1;
        `CHK("wake", c[0], 1'(wake_cnt - w0))
        `CHK("standby", c[40] & ~c[0], standby_out)
        `CHK("irq", c[0] & c[4], irq_out)
        rd(cspw_pkg::OFS_IRQ_STATUS, d);
        `CHK("status", c[0], d[0])
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ****************************************
    // clock, watchdog, wake counter
    // ****************************************
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    initial begin
        #(40000 * 20);
        n_mismatch++;
        finish_test();
    end
    always @(posedge clk_in) if (wake_out === 1'b1) wake_cnt <= wake_cnt + 1;
    always @(posedge clk_in) if (conv[1] === 1'b1) conv_cnt <= conv_cnt + 1;
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_b_in, wr_in, rd_in, addr_in, wdata_in, v1, v2} = '0;
        th1 = {12'h100, 12'h080};
        th2 = {12'hFFF, 12'hFFF};
        ch2_en = 2'h3;
        x = 8'($urandom(32'h8F89));
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        foreach (ofs[i]) begin
            rd(ofs[i], d);
            `CHK("reset", 8'h00, d)
        end
        for (int c = 0; c < 4; c++) begin
            x = 8'($urandom());
            x[5:4] = 2'(c);
            wr(cspw_pkg::OFS_RANGE, x);
            rd(cspw_pkg::OFS_RANGE, d);
            `CHK("range", x & 8'h33, d)
            `CHK("ch2_pf", pf(2'(c)), pf2)
            `CHK("ch1_pf", pf(x[1:0]), pf1)
        end
        for (int i = 0; i < 6; i++) begin
            x = 8'($urandom());
            x[0] = 1'(i);
            wr(cspw_pkg::OFS_POWER, x);
            rd(cspw_pkg::OFS_POWER, d);
            `CHK("pd", x & 8'h07, d)
            `CHK("sb", x[0], standby_out)
            `CHK("ch1_off", x[1], ch1_off)
            `CHK("ch2_off", x[2], ch2_off)
            x = 8'($urandom());
            wr(cspw_pkg::OFS_WAKE1, x);
            rd(cspw_pkg::OFS_WAKE1, d);
            `CHK("wake1", x & 8'h03, d)
        end
        wr(8'h20, 8'hFF);
        rd(8'h20, d);
        `CHK("unmapped", 8'h00, d)
        foreach (cs[i]) wake_case(cs[i]);
        wr(cspw_pkg::OFS_POWER, 8'h03);
        wr(cspw_pkg::OFS_SB_DIV, 8'h03);
        repeat (2100) @(posedge clk_in);
        w0 = conv_cnt;
        repeat (4000) @(posedge clk_in);
        `CHK("sb_rate", 2, conv_cnt - w0)
        finish_test();
    end
endmodule
`default_nettype wire
